/* logic/modulator_pkg.sv */
/*
 * Constants shared by the signal modulator: register byte offsets, writable
 * masks, reset values, field positions and the source select encodings.
 * Assumes a 32-bit APB slave with 8-bit byte addresses, one register per word.
 */
package modulator_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL_MAIN     = 8'h00;
  localparam logic [7:0] OFS_CARRIER_CONTROL  = 8'h04;
  localparam logic [7:0] OFS_HIGH_CARRIER_SEL = 8'h08;
  localparam logic [7:0] OFS_LOW_CARRIER_SEL  = 8'h0c;
  localparam logic [7:0] OFS_MODULATING_SEL   = 8'h10;
  localparam logic [7:0] OFS_LOW_PIN_SEL      = 8'h14;
  localparam logic [7:0] OFS_HIGH_PIN_SEL     = 8'h18;
  localparam logic [7:0] OFS_MOD_PIN_SEL      = 8'h1c;
  localparam logic [7:0] OFS_OUTPUT_ROUTE     = 8'h20;
  localparam logic [7:0] OFS_POWER_DOWN       = 8'h24;

  // ----------------------------------------------------------------------
  // Writable bit masks
  // ----------------------------------------------------------------------
  localparam logic [7:0] WMASK_CONTROL_MAIN    = 8'h91;
  localparam logic [7:0] WMASK_CARRIER_CONTROL = 8'h33;
  localparam logic [7:0] WMASK_CARRIER_SEL     = 8'h07;
  localparam logic [7:0] WMASK_MODULATING_SEL  = 8'h0f;
  localparam logic [7:0] WMASK_PIN_SEL         = 8'h1f;
  localparam logic [7:0] WMASK_POWER_DOWN      = 8'h01;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_CONTROL_MAIN    = 8'h00;
  localparam logic [7:0] RST_CARRIER_CONTROL = 8'h00;
  localparam logic [7:0] RST_CARRIER_SEL     = 8'h00;
  localparam logic [7:0] RST_MODULATING_SEL  = 8'h00;
  localparam logic [7:0] RST_PIN_SEL         = 8'h00;
  localparam logic [7:0] RST_POWER_DOWN      = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned MODULATOR_ENABLE_BIT    = 7;
  localparam int unsigned OUTPUT_STATUS_BIT       = 5;
  localparam int unsigned OUTPUT_INVERT_BIT       = 4;
  localparam int unsigned PROGRAMMED_MOD_BIT      = 0;
  localparam int unsigned HIGH_CARRIER_INVERT_BIT = 5;
  localparam int unsigned HIGH_CARRIER_SYNC_BIT   = 4;
  localparam int unsigned LOW_CARRIER_INVERT_BIT  = 1;
  localparam int unsigned LOW_CARRIER_SYNC_BIT    = 0;
  localparam int unsigned MODULATOR_POWER_BIT     = 0;

  // ----------------------------------------------------------------------
  // Source encodings
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    CAR_PIN      = 3'h0,
    CAR_SYSCLK   = 3'h1,
    CAR_FAST_OSC = 3'h2,
    CAR_REF_CLK  = 3'h3,
    CAR_CMP_ONE  = 3'h4,
    CAR_CMP_TWO  = 3'h5,
    CAR_PWM_3    = 3'h6,
    CAR_PWM_4    = 3'h7
  } carrier_sel_e;

  typedef enum logic [3:0] {
    MOD_PIN      = 4'h0,
    MOD_PROG_BIT = 4'h1
  } mod_sel_e;

endpackage : modulator_pkg

/* logic/mix_if.sv */
/*
 * Signals passed between the register side of the modulator and its carrier mixer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface mix_if;
  logic mod_level;
  logic high_raw;
  logic low_raw;
  logic high_inv;
  logic low_inv;
  logic high_sync;
  logic low_sync;
  logic active;
  logic mixed;

  modport main (
    output mod_level, high_raw, low_raw, high_inv, low_inv,
    output high_sync, low_sync, active,
    input  mixed
  );
  modport mixer (
    input  mod_level, high_raw, low_raw, high_inv, low_inv,
    input  high_sync, low_sync, active,
    output mixed
  );
endinterface : mix_if

/* logic/carrier_mixer.sv */
/*
 * Carrier mixer: applies carrier polarity, tracks which carrier is in use and
 * delays a carrier change until the carrier being left has gone low.
 * Assumes all inputs are synchronous to clock.
 */
`timescale 1ns/1ps
module carrier_mixer (
  input wire logic clock,
  input wire logic rst,
  mix_if.mixer     mx
);

  typedef struct packed {
    logic use_high;
  } mix_state_s;

  mix_state_s st;
  mix_state_s next_st;
  logic       high_adj;
  logic       low_adj;

  assign high_adj = mx.high_raw ^ mx.high_inv;
  assign low_adj  = mx.low_raw ^ mx.low_inv;

  // --------------------------------------------------------------------
  // Carrier change
  // --------------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (!mx.active) begin
      next_st.use_high = mx.mod_level;
    end else if (mx.mod_level != st.use_high) begin
      if (st.use_high) begin
        if (!mx.high_sync || !high_adj) begin
          next_st.use_high = 1'b0;
        end
      end else begin
        if (!mx.low_sync || !low_adj) begin
          next_st.use_high = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // With neither carrier synchronised, or the block disabled, the output follows the modulating level at once
  assign mx.mixed = (mx.active && (mx.high_sync || mx.low_sync))
                  ? (st.use_high ? high_adj : low_adj)
                  : (mx.mod_level ? high_adj : low_adj);

endmodule : carrier_mixer

/* logic/signal_modulator.sv */
/*
 * Signal modulator top: APB register file, source multiplexers for the
 * modulating signal and both carriers, output polarity and pin drive.
 * Assumes every source input is synchronous to clock and that the APB master
 * follows the usual setup/access sequence.
 */
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
module signal_modulator (
  input  wire logic                               clock,
  input  wire logic                               rst,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [modulator_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [modulator_pkg::DATA_W-1:0]   pwdata,
  output logic      [modulator_pkg::DATA_W-1:0]   prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  input  wire logic                               mod_pin_in,
  input  wire logic                               high_carrier_pin_in,
  input  wire logic                               low_carrier_pin_in,
  input  wire logic                               sys_clock_tap,
  input  wire logic                               fast_internal_osc,
  input  wire logic                               reference_clock_out,
  input  wire logic                               compare_unit_one,
  input  wire logic                               compare_unit_two,
  input  wire logic                               pwm_three,
  input  wire logic                               pwm_four,
  input  wire logic                               comparator_one,
  input  wire logic                               comparator_two,
  input  wire logic                               uart_one_rx,
  input  wire logic                               uart_one_tx,
  input  wire logic                               uart_two_rx,
  input  wire logic                               uart_two_tx,
  input  wire logic                               sync_serial_one_sdo,
  input  wire logic                               sync_serial_two_sdo,
  output logic      [4:0]                         low_carrier_pin_sel,
  output logic      [4:0]                         high_carrier_pin_sel,
  output logic      [4:0]                         modulating_pin_sel,
  output logic      [4:0]                         output_route_sel,
  output logic                                    modulated_out
);
  import modulator_pkg::*;

  typedef struct packed {
    logic [7:0]        control_main;
    logic [7:0]        carrier_control;
    logic [7:0]        high_carrier_select;
    logic [7:0]        low_carrier_select;
    logic [7:0]        modulating_source_select;
    logic [7:0]        low_carrier_pin_select;
    logic [7:0]        high_carrier_pin_select;
    logic [7:0]        modulating_pin_select;
    logic [7:0]        output_pin_route;
    logic [7:0]        power_down;
    logic [DATA_W-1:0] rdata;
    logic              ready;
    logic              slverr;
    logic              pin_out;
  } top_state_s;

  top_state_s st;
  top_state_s next_st;
  mix_if      mx ();

  logic       enabled;
  logic [2:0] eff_high_sel;
  logic [2:0] eff_low_sel;
  logic [3:0] eff_mod_sel;
  logic [7:0] carrier_vec_high;
  logic [7:0] carrier_vec_low;
  logic [15:0] mod_vec;
  logic       setup_phase;
  logic       access_phase;

  // --------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------
  function automatic logic carrier_pick(input logic [2:0] sel, input logic [7:0] vec);
    carrier_pick = vec[sel];
  endfunction : carrier_pick

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_CONTROL_MAIN, OFS_CARRIER_CONTROL, OFS_HIGH_CARRIER_SEL,
      OFS_LOW_CARRIER_SEL, OFS_MODULATING_SEL, OFS_LOW_PIN_SEL,
      OFS_HIGH_PIN_SEL, OFS_MOD_PIN_SEL, OFS_OUTPUT_ROUTE,
      OFS_POWER_DOWN: addr_mapped = 1'b1;
      default:        addr_mapped = 1'b0;
    endcase
  endfunction : addr_mapped

  function automatic logic [7:0] read_byte(input top_state_s s, input logic [ADDR_W-1:0] a);
    case (a)
      OFS_CONTROL_MAIN: begin
        read_byte = s.control_main;
        read_byte[OUTPUT_STATUS_BIT] = s.pin_out;
      end
      OFS_CARRIER_CONTROL:  read_byte = s.carrier_control;
      OFS_HIGH_CARRIER_SEL: read_byte = s.high_carrier_select;
      OFS_LOW_CARRIER_SEL:  read_byte = s.low_carrier_select;
      OFS_MODULATING_SEL:   read_byte = s.modulating_source_select;
      OFS_LOW_PIN_SEL:      read_byte = s.low_carrier_pin_select;
      OFS_HIGH_PIN_SEL:     read_byte = s.high_carrier_pin_select;
      OFS_MOD_PIN_SEL:      read_byte = s.modulating_pin_select;
      OFS_OUTPUT_ROUTE:     read_byte = s.output_pin_route;
      OFS_POWER_DOWN:       read_byte = s.power_down;
      default:              read_byte = 8'h00;
    endcase
  endfunction : read_byte

  // --------------------------------------------------------------------
  // Source selection
  // --------------------------------------------------------------------
  // Sleep has no input here: the block keeps running whenever its sources do
  assign enabled = st.control_main[MODULATOR_ENABLE_BIT]
                 & ~st.power_down[MODULATOR_POWER_BIT];

  // Stored selects stay untouched; only the applied copy is forced
  assign eff_high_sel = enabled ? st.high_carrier_select[2:0] : CAR_PIN;
  assign eff_low_sel  = enabled ? st.low_carrier_select[2:0] : CAR_PIN;
  assign eff_mod_sel  = enabled ? st.modulating_source_select[3:0]
                                : MOD_PROG_BIT;

  assign carrier_vec_high = {pwm_four, pwm_three, compare_unit_two, compare_unit_one,
                             reference_clock_out, fast_internal_osc, sys_clock_tap,
                             high_carrier_pin_in};
  assign carrier_vec_low  = {pwm_four, pwm_three, compare_unit_two, compare_unit_one,
                             reference_clock_out, fast_internal_osc, sys_clock_tap,
                             low_carrier_pin_in};

  // Codes 14 and 15 are reserved and read as a low modulating level
  assign mod_vec = {2'b00, sync_serial_two_sdo, sync_serial_one_sdo,
                    uart_two_tx, uart_two_rx, uart_one_tx, uart_one_rx,
                    comparator_two, comparator_one, pwm_four, pwm_three,
                    compare_unit_two, compare_unit_one,
                    st.control_main[PROGRAMMED_MOD_BIT], mod_pin_in};

  assign mx.mod_level = mod_vec[eff_mod_sel];
  assign mx.high_raw  = carrier_pick(eff_high_sel, carrier_vec_high);
  assign mx.low_raw   = carrier_pick(eff_low_sel, carrier_vec_low);
  assign mx.high_inv  = st.carrier_control[HIGH_CARRIER_INVERT_BIT];
  assign mx.low_inv   = st.carrier_control[LOW_CARRIER_INVERT_BIT];
  assign mx.high_sync = st.carrier_control[HIGH_CARRIER_SYNC_BIT];
  assign mx.low_sync  = st.carrier_control[LOW_CARRIER_SYNC_BIT];
  assign mx.active    = enabled;

  carrier_mixer i_carrier_mixer (
    .clock (clock),
    .rst   (rst),
    .mx    (mx.mixer)
  );

  // --------------------------------------------------------------------
  // APB slave and register file
  // --------------------------------------------------------------------
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable & st.ready;

  always_comb begin
    next_st        = st;
    next_st.ready  = 1'b0;
    next_st.slverr = 1'b0;

    if (setup_phase) begin
      next_st.ready  = 1'b1;
      next_st.slverr = ~addr_mapped(paddr);
      next_st.rdata  = pwrite ? '0 : {24'h000000, read_byte(st, paddr)};
    end

    if (access_phase && pwrite) begin
      case (paddr)
        OFS_CONTROL_MAIN:     next_st.control_main = pwdata[7:0] & WMASK_CONTROL_MAIN;
        OFS_CARRIER_CONTROL:  next_st.carrier_control =
                                pwdata[7:0] & WMASK_CARRIER_CONTROL;
        OFS_HIGH_CARRIER_SEL: next_st.high_carrier_select = pwdata[7:0] & WMASK_CARRIER_SEL;
        OFS_LOW_CARRIER_SEL:  next_st.low_carrier_select = pwdata[7:0] & WMASK_CARRIER_SEL;
        OFS_MODULATING_SEL:   next_st.modulating_source_select =
                                pwdata[7:0] & WMASK_MODULATING_SEL;
        OFS_LOW_PIN_SEL:      next_st.low_carrier_pin_select = pwdata[7:0] & WMASK_PIN_SEL;
        OFS_HIGH_PIN_SEL:     next_st.high_carrier_pin_select = pwdata[7:0] & WMASK_PIN_SEL;
        OFS_MOD_PIN_SEL:      next_st.modulating_pin_select = pwdata[7:0] & WMASK_PIN_SEL;
        OFS_OUTPUT_ROUTE:     next_st.output_pin_route = pwdata[7:0] & WMASK_PIN_SEL;
        OFS_POWER_DOWN:       next_st.power_down = pwdata[7:0] & WMASK_POWER_DOWN;
        default: ;
      endcase
    end

    // Powered-down block holds every register except power_down at its power-on value
    if (st.power_down[MODULATOR_POWER_BIT]) begin
      next_st.control_main             = RST_CONTROL_MAIN;
      next_st.carrier_control          = RST_CARRIER_CONTROL;
      next_st.high_carrier_select      = RST_CARRIER_SEL;
      next_st.low_carrier_select       = RST_CARRIER_SEL;
      next_st.modulating_source_select = RST_MODULATING_SEL;
      next_st.low_carrier_pin_select   = RST_PIN_SEL;
      next_st.high_carrier_pin_select  = RST_PIN_SEL;
      next_st.modulating_pin_select    = RST_PIN_SEL;
      next_st.output_pin_route         = RST_PIN_SEL;
    end

    // Pin stays low while disabled, whatever the polarity bit says
    next_st.pin_out = enabled
                    ? (mx.mixed ^ st.control_main[OUTPUT_INVERT_BIT])
                    : 1'b0;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st.control_main             <= RST_CONTROL_MAIN;
      st.carrier_control          <= RST_CARRIER_CONTROL;
      st.high_carrier_select      <= RST_CARRIER_SEL;
      st.low_carrier_select       <= RST_CARRIER_SEL;
      st.modulating_source_select <= RST_MODULATING_SEL;
      st.low_carrier_pin_select   <= RST_PIN_SEL;
      st.high_carrier_pin_select  <= RST_PIN_SEL;
      st.modulating_pin_select    <= RST_PIN_SEL;
      st.output_pin_route         <= RST_PIN_SEL;
      st.power_down               <= RST_POWER_DOWN;
      st.rdata                    <= '0;
      st.ready                    <= 1'b0;
      st.slverr                   <= 1'b0;
      st.pin_out                  <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign prdata               = st.rdata;
  assign pready               = st.ready;
  assign pslverr              = st.slverr;
  assign modulated_out        = st.pin_out;
  assign low_carrier_pin_sel  = st.low_carrier_pin_select[4:0];
  assign high_carrier_pin_sel = st.high_carrier_pin_select[4:0];
  assign modulating_pin_sel   = st.modulating_pin_select[4:0];
  assign output_route_sel     = st.output_pin_route[4:0];

endmodule : signal_modulator

/* verification/signal_modulator_monitor.sv */
/* Port checker for the signal modulator: APB answer timing and the enable,
   power-down and pin-select effects seen at the top ports.
   Assumes one clock domain and an asynchronous active-high reset. */
`timescale 1ns/1ps
module signal_modulator_monitor (
  input wire logic                             clock,
  input wire logic                             rst,
  input wire logic                             psel,
  input wire logic                             penable,
  input wire logic                             pwrite,
  input wire logic [modulator_pkg::ADDR_W-1:0] paddr,
  input wire logic [modulator_pkg::DATA_W-1:0] pwdata,
  input wire logic [modulator_pkg::DATA_W-1:0] prdata,
  input wire logic                             pready,
  input wire logic                             pslverr,
  input wire logic [4:0]                       low_carrier_pin_sel,
  input wire logic                             modulated_out
);
  import modulator_pkg::*;
  logic wr;
  logic pd_q;
  logic en_q;
  assign wr = psel && penable && pready && pwrite;
  // Shadow of the enable and power-down bits as written over the bus
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pd_q <= 1'b0;
      en_q <= 1'b0;
    end else if (wr && paddr == OFS_POWER_DOWN) begin
      pd_q <= pwdata[0];
      en_q <= en_q && !pwdata[0];
    end else if (wr && paddr == OFS_CONTROL_MAIN && !pd_q) begin
      en_q <= pwdata[7];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready one cycle after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_unmapped: assert property (pready && paddr > OFS_POWER_DOWN |-> pslverr && prdata == '0)
    else $error("unmapped access not refused");
  a_ok_mapped: assert property (pready && paddr <= OFS_POWER_DOWN && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_enable_read: assert property (pready && !pwrite && paddr == OFS_CONTROL_MAIN |-> prdata[7] == en_q)
    else $error("enable bit reads wrong");
  a_status_mirror: assert property (pready && !pwrite && paddr == OFS_CONTROL_MAIN
                                    |-> prdata[5] == $past(modulated_out))
    else $error("status bit does not show the output");
  a_off_low: assert property (!en_q |=> !modulated_out)
    else $error("output not low while disabled");
  a_pd_clears: assert property (pd_q && $past(pd_q) |-> low_carrier_pin_sel == 5'h00)
    else $error("register not cleared in power-down");
  a_pin_write: assert property (wr && paddr == OFS_LOW_PIN_SEL && !pd_q
                                |=> low_carrier_pin_sel == $past(pwdata[4:0]))
    else $error("pin select not updated");
endmodule : signal_modulator_monitor

bind signal_modulator signal_modulator_monitor i_signal_modulator_monitor (
  .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .low_carrier_pin_sel(low_carrier_pin_sel), .modulated_out(modulated_out));

/* verification/source_model.sv */
/* Stand-ins for the pins, clocks, timers and serial lines feeding the modulator.
   Assumes one clock; every source changes just after a rising edge. */
`timescale 1ns/1ps
module source_model (
  input  wire logic        clock,
  input  wire logic        rst,
  output logic      [17:0] src
);
  logic [15:0] tick;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick <= 16'h0000;
    end else begin
      tick <= tick + 16'h0001;
    end
  end
  // Each source mixes two divider taps so neighbours differ in rate and phase
  always_comb begin
    for (int i = 0; i < 18; i++) begin
      src[i] = tick[i % 5] ^ tick[(i % 3) + 5];
    end
  end
endmodule : source_model

/* verification/signal_modulator_test.sv */
/* Self-checking bench for the signal modulator: APB register checks and a
   cycle reference of the modulated pin.
   Assumes the source model feeds every source input. */
`timescale 1ns/1ps
module signal_modulator_test;
  import modulator_pkg::*;
  logic        clock, rst, psel, penable, pwrite, pready, pslverr, modulated_out;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [17:0] src;
  logic [19:0] pins;
  logic [32:0] rd_q[$];
  logic        out_q[$];
  logic        watch, en, oinv, prog, hinv, hs, linv, ls, pd, cur;
  logic [2:0]  hsel, lsel;
  logic [3:0]  msel;
  int          failures, cmp_count;

  source_model i_source_model (.clock(clock), .rst(rst), .src(src));
  signal_modulator i_signal_modulator (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mod_pin_in(src[0]), .high_carrier_pin_in(src[1]), .low_carrier_pin_in(src[2]),
    .sys_clock_tap(src[3]), .fast_internal_osc(src[4]), .reference_clock_out(src[5]),
    .compare_unit_one(src[6]), .compare_unit_two(src[7]), .pwm_three(src[8]),
    .pwm_four(src[9]), .comparator_one(src[10]), .comparator_two(src[11]),
    .uart_one_rx(src[12]), .uart_one_tx(src[13]), .uart_two_rx(src[14]),
    .uart_two_tx(src[15]), .sync_serial_one_sdo(src[16]), .sync_serial_two_sdo(src[17]),
    .low_carrier_pin_sel(pins[19:15]), .high_carrier_pin_sel(pins[14:10]),
    .modulating_pin_sel(pins[9:5]), .output_route_sel(pins[4:0]),
    .modulated_out(modulated_out));

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [32:0] exp, input logic [32:0] got, input string what);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  function automatic logic car(input logic [2:0] c, input logic pin);
    return (c == 3'h0) ? pin : src[int'(c) + 2];
  endfunction : car

  task automatic mirror(input logic [7:0] a, input logic [31:0] d);
    case (a)
      OFS_CONTROL_MAIN: {en, oinv, prog} = {d[7], d[4], d[0]};
      OFS_CARRIER_CONTROL: {hinv, hs, linv, ls} = {d[5], d[4], d[1], d[0]};
      OFS_HIGH_CARRIER_SEL: hsel = d[2:0];
      OFS_LOW_CARRIER_SEL: lsel = d[2:0];
      OFS_MODULATING_SEL: msel = d[3:0];
      OFS_POWER_DOWN: begin
        pd = d[0];
        if (d[0]) {en, oinv, prog, hinv, hs, linv, ls, hsel, lsel, msel} = '0;
      end
      default: ;
    endcase
  endtask : mirror

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      print_verdict();
    end
    {psel, penable} <= 2'b00;
    if (wr && (!pd || a == OFS_POWER_DOWN)) mirror(a, d);
    @(posedge clock);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic e);
    rd_q.push_back({e, 24'h000000, d});
    apb(1'b0, a, 32'h0);
  endtask : rd

  // --------------------------------------------------------------------
  // Reference of the pin and result watchers
  // --------------------------------------------------------------------
  always @(negedge clock) begin : reference
    logic m, h, l;
    m = (!en || msel == 4'h1) ? prog : (msel == 4'h0) ? src[0] :
        (msel > 4'hd) ? 1'b0 : src[int'(msel) + 4];
    h = (en ? car(hsel, src[1]) : src[1]) ^ hinv;
    l = (en ? car(lsel, src[2]) : src[2]) ^ linv;
    if (watch) out_q.push_back(en && (((hs || ls) ? cur : m) ? h : l) ^ oinv);
    if (rst) cur = 1'b0;
    else if (!en || (m != cur && (cur ? (!hs || !h) : (!ls || !l)))) cur = m;
  end

  always @(posedge clock) begin : out_watch
    #1;
    if (out_q.size() > 0) check({32'h0, out_q.pop_front()}, {32'h0, modulated_out}, "pin");
  end

  always @(posedge clock) begin : read_watch
    if (psel && penable && pready && !pwrite && rd_q.size() > 0)
      check(rd_q.pop_front(), {pslverr, prdata}, "read");
  end

  initial begin : clock_gen
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin : limit
    repeat (50000) @(posedge clock);
    failures++;
    print_verdict();
  end

  initial begin : main
    {rst, psel, penable, pwrite, paddr, pwdata, watch} = {1'b1, 44'h0};
    {en, oinv, prog, hinv, hs, linv, ls, pd, cur, hsel, lsel, msel} = '0;
    failures = 0;
    cmp_count = 0;
    r = $urandom(95);
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    watch = 1'b1;
    for (int i = 0; i < 10; i++) rd(8'(i * 4), 8'h00, 1'b0);
    rd(8'h28, 8'h00, 1'b1);
    $display("test reset_values done");
    for (int i = 1; i < 9; i++) apb(1'b1, 8'(i * 4), 32'hffffffff);
    check(33'hfffff, {13'h0, pins}, "pin selects");
    for (int i = 1; i < 9; i++) rd(8'(i * 4), (i == 1) ? WMASK_CARRIER_CONTROL : (i < 4) ?
      WMASK_CARRIER_SEL : (i == 4) ? WMASK_MODULATING_SEL : WMASK_PIN_SEL, 1'b0);
    $display("test access_masks done");
    apb(1'b1, OFS_POWER_DOWN, 32'h1);
    apb(1'b1, OFS_HIGH_CARRIER_SEL, 32'h5);
    rd(OFS_POWER_DOWN, 8'h01, 1'b0);
    apb(1'b1, OFS_POWER_DOWN, 32'h0);
    for (int i = 0; i < 9; i++) rd(8'(i * 4), 8'h00, 1'b0);
    check(33'h0, {13'h0, pins}, "pin selects");
    $display("test power_down done");
    for (int m = 0; m < 16; m++) begin
      r = $urandom();
      apb(1'b1, OFS_HIGH_CARRIER_SEL, r & 32'h7);
      apb(1'b1, OFS_LOW_CARRIER_SEL, (r >> 3) & 32'h7);
      apb(1'b1, OFS_CARRIER_CONTROL, r & 32'h22);
      apb(1'b1, OFS_LOW_PIN_SEL, (r >> 8) & 32'h1f);
      apb(1'b1, OFS_MODULATING_SEL, 32'(m));
      apb(1'b1, OFS_CONTROL_MAIN, 32'h80 | (r & 32'h11));
      repeat (16) @(posedge clock);
      apb(1'b1, OFS_CONTROL_MAIN, 32'h80 | ((r ^ 32'h1) & 32'h11));
      repeat (8) @(posedge clock);
    end
    $display("test source_mix done");
    apb(1'b1, OFS_MODULATING_SEL, 32'h7);
    apb(1'b1, OFS_HIGH_CARRIER_SEL, 32'h3);
    apb(1'b1, OFS_LOW_CARRIER_SEL, 32'h6);
    apb(1'b1, OFS_CONTROL_MAIN, 32'h10);
    repeat (16) @(posedge clock);
    rd(OFS_MODULATING_SEL, 8'h07, 1'b0);
    rd(OFS_HIGH_CARRIER_SEL, 8'h03, 1'b0);
    rd(OFS_LOW_CARRIER_SEL, 8'h06, 1'b0);
    rd(OFS_CONTROL_MAIN, 8'h10, 1'b0);
    apb(1'b1, OFS_CONTROL_MAIN, 32'h90);
    repeat (16) @(posedge clock);
    $display("test disable done");
    apb(1'b1, OFS_MODULATING_SEL, 32'h1);
    for (int s = 1; s < 4; s++) begin
      apb(1'b1, OFS_CARRIER_CONTROL, 32'(((s & 2) << 3) | (s & 1)) | (r & 32'h22));
      for (int k = 0; k < 8; k++) begin
        apb(1'b1, OFS_CONTROL_MAIN, 32'h80 | 32'(k & 1));
        repeat (k + 1) @(posedge clock);
      end
    end
    $display("test carrier_sync done");
    print_verdict();
  end
endmodule : signal_modulator_test
